// >>> src/hrcs_pkg.sv
// hrcs_pkg: constants, register layouts and types of the hub reset sequencer
// assumes a 250 MHz core clock and an AXI4-Lite master on the register side
// Overview of operation
// R1 - reset pin held low at least 1 us once supplies are good
// R2 - while reset pin low, ports disabled and port power removed
// R3 - while reset pin low, transceivers off, pairs high impedance
// R4 - reset pin aborts every transaction at once, nothing kept; the code leaves bvalid_q, rvalid_q and rdata_q, cleared by aresetn only
// R5 - reset pin returns every register to its default, mostly zero
// R6 - reset pin stops the oscillator and the pll
// R7 - reset pin disables the led outputs
// R8 - operational within 500 us of release, then eeprom read unless smbus mode; the code starts the eeprom read in eeprom mode only
// R9 - eeprom read and configuration finish within 99.5 ms, 2.0 ms typical
// R10 - smbus host loads configuration within 99.5 ms when bus powered
// R11 - attach upstream within 100 ms of configuration load done
// R12 - host waits at least 100 ms after attach before bus reset
// R13 - each upstream request completes within 5 ms
// R14 - default mode loads the built-in value of every setting
// R15 - strap mode samples both led pins 16.7 to 1400 ns after release
// R16 - led strapped high drives active low, strapped low active high
// R17 - strap mode uses built-in values for every unstrapped setting
// R18 - bus reset sets address 0 and unconfigured state
// R19 - bus reset removes power on downstream ports 7 to 1
// R20 - bus reset clears tt buffers and leaves suspend
// R21 - bus reset is never passed to downstream ports
// R22 - tester sets test pin, select bit 1 high, serial clock low, releases reset
// R23 - test mode drives xnor of tested pins onto green led 2
// R24 - reset pin release synchronised before recovery timer and strap sampling
package hrcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int  CLK_PERIOD_PS  = 4000;
  localparam real T_STRAP_MIN_NS = 16.7;
  localparam real T_STRAP_MAX_NS = 1400.0;
  localparam real T_RECOVER_US   = 500.0;
  localparam real T_CFG_MAX_MS   = 99.5;
  localparam real T_REQ_MAX_MS   = 5.0;
  localparam int  STRAP_MIN_CYC  = int'($ceil(T_STRAP_MIN_NS * 1.0e3 / CLK_PERIOD_PS));
  localparam int  STRAP_MAX_CYC  = int'($floor(T_STRAP_MAX_NS * 1.0e3 / CLK_PERIOD_PS));
  localparam int  RECOVER_CYC_DFLT = int'($floor(T_RECOVER_US * 1.0e6 / CLK_PERIOD_PS));
  localparam int  CFG_TMO_CYC_DFLT = int'($floor(T_CFG_MAX_MS * 1.0e9 / CLK_PERIOD_PS));
  localparam int  REQ_TMO_CYC_DFLT = int'($floor(T_REQ_MAX_MS * 1.0e9 / CLK_PERIOD_PS));
  localparam int  CNT_W          = 25;

  ////////////////////////////////////////////////////////////////////////////
  // widths and register map
  localparam int          NPORT      = 7;
  localparam int          TEST_W     = 32;
  localparam int          LED_GREEN  = 0;
  localparam int          LED_AMBER  = 1;
  localparam int          AXI_AW     = 8;
  localparam int          AXI_DW     = 32;
  localparam int          AXI_SW     = AXI_DW / 8;
  localparam int          ADDR_LSB   = 2;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_ADDR   = 8'h04;
  localparam logic [7:0]  REG_STAT   = 8'h08;
  localparam logic [31:0] REG_RST    = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_03fe;
  localparam logic [31:0] ADDR_WMASK = 32'h0000_017f;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_HWRST    = 3'h0,
    ST_RECOVER  = 3'h1,
    ST_LOAD     = 3'h3,
    ST_CONFIG   = 3'h2,
    ST_ATTACHED = 3'h6
  } hrcs_state_t;

  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'h0,
    MODE_STRAP   = 2'h1,
    MODE_EEPROM  = 2'h2,
    MODE_SMBUS   = 2'h3
  } hrcs_mode_t;

  typedef struct packed {
    logic [21:0]      rsvd;
    logic [1:0]       led_on;
    logic [NPORT-1:0] ppe;
    logic             rsvd0;
  } hrcs_ctrl_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        configured;
    logic        rsvd0;
    logic [6:0]  dev_addr;
  } hrcs_addr_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic        suspended;
    logic        attached;
    logic        cfg_tmo;
    logic        test;
    logic [1:0]  strap;
    hrcs_mode_t  mode;
    hrcs_state_t state;
  } hrcs_stat_t;

  typedef struct packed {
    logic              hw_rst_n;
    logic [1:0]        cfg_sel;
    logic              test;
    logic              sclk;
    logic [1:0]        led;
    logic [TEST_W-1:0] tp;
  } hrcs_pins_t;

  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [AXI_DW-1:0] wdata;
    logic [AXI_SW-1:0] wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } hrcs_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
  } hrcs_axi_rsp_t;

endpackage : hrcs_pkg

// >>> src/hrcs_sync.sv
// hrcs_sync: two-flop synchroniser for pads entering the core clock
// assumes inputs asynchronous to aclk; output follows two edges later
module hrcs_sync #(
  parameter int W = 1
) (
  input  logic         aclk,
  input  logic         aresetn,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : hrcs_sync

// >>> src/hrcs_sequencer.sv
// hrcs_sequencer: hub reset pin handling, configuration load, attach,
// upstream bus reset response and continuity test output
// assumes eeprom/smbus engines and the usb core run on aclk; pads do not
module hrcs_sequencer #(
  parameter int unsigned RECOVER_CYC = hrcs_pkg::RECOVER_CYC_DFLT,
  parameter int unsigned CFG_TMO_CYC = hrcs_pkg::CFG_TMO_CYC_DFLT,
  parameter int unsigned REQ_TMO_CYC = hrcs_pkg::REQ_TMO_CYC_DFLT
) (
  input  logic                            aclk,
  input  logic                            aresetn,
  input  hrcs_pkg::hrcs_axi_req_t         axi_req,
  output hrcs_pkg::hrcs_axi_rsp_t         axi_rsp,
  input  logic                            hw_reset_n_pin,
  input  logic [1:0]                      cfg_sel_pin,
  input  logic                            test_mode_pin,
  input  logic                            sclk_pin,
  input  logic [hrcs_pkg::TEST_W-1:0]     test_pins,
  input  logic                            amber_led_pin_i,
  output logic                            amber_led_pin_o,
  output logic                            amber_led_pin_oe,
  input  logic                            green_led2_pin_i,
  output logic                            green_led2_pin_o,
  output logic                            green_led2_pin_oe,
  input  logic                            self_powered,
  output logic                            eeprom_start,
  input  logic                            eeprom_done,
  input  logic                            smbus_done,
  output logic                            cfg_use_default,
  output logic [1:0]                      cfg_strap,
  output logic                            usb_attach,
  input  logic                            usb_bus_reset,
  input  logic                            usb_suspend,
  output logic                            tt_clear,
  input  logic                            req_busy,
  output logic                            req_abort,
  output logic [hrcs_pkg::NPORT:1]        port_power_enable,
  output logic [hrcs_pkg::NPORT:1]        port_enable,
  output logic                            phy_en,
  output logic                            osc_en,
  output logic                            pll_en,
  output logic [6:0]                      dev_addr,
  output logic                            configured
);
  import hrcs_pkg::*;

  hrcs_pins_t       pins_raw;
  hrcs_pins_t       pins_s;
  logic             core_clr;
  hrcs_state_t      state_q;
  hrcs_mode_t       mode_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] req_cnt_q;
  logic             test_q;
  logic [1:0]       strap_q;
  logic             strap_now;
  logic             load_done;
  logic             load_tmo;
  logic             cfg_tmo_q;
  logic             attach_q;
  logic             suspended_q;
  hrcs_ctrl_t       ctrl_q;
  hrcs_addr_t       addr_q;
  hrcs_stat_t       stat;
  logic             wr_go;
  logic             rd_go;
  logic             bvalid_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // word decode of a bus address
  function automatic logic hit(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] off);
    return a[AXI_AW-1:ADDR_LSB] == off[AXI_AW-1:ADDR_LSB];
  endfunction : hit

  // byte-lane merge of a write, reserved bits forced to zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [AXI_SW-1:0] be, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < AXI_SW; b++)
      if (be[b])
        res[b*8 +: 8] = wd[b*8 +: 8];
    return res & mask;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // pad synchronisation

  // gather pads into one bundle
  always_comb
  begin
    pins_raw.hw_rst_n = hw_reset_n_pin;
    pins_raw.cfg_sel  = cfg_sel_pin;
    pins_raw.test     = test_mode_pin;
    pins_raw.sclk     = sclk_pin;
    pins_raw.led      = {amber_led_pin_i, green_led2_pin_i};
    pins_raw.tp       = test_pins;
  end

  hrcs_sync #(
    .W ($bits(hrcs_pins_t))
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // pin reset acts only after two flops [R24]
  assign core_clr = !aresetn || !pins_s.hw_rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // completion of the selected configuration source
  always_comb
  begin
    case (mode_q)
      MODE_EEPROM: load_done = eeprom_done;
      MODE_SMBUS:  load_done = smbus_done;
      MODE_STRAP:  load_done = 1'b1;
      MODE_DEFAULT: load_done = 1'b1;
    endcase
  end

  // load time limit, eeprom always, smbus only when bus powered [R9] [R10]
  assign load_tmo = (mode_q == MODE_EEPROM || (mode_q == MODE_SMBUS && !self_powered))
                    && cnt_q == CNT_W'(CFG_TMO_CYC - 1);

  // main state walk, wiped by the reset pin [R4]
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      state_q <= ST_HWRST;
      cnt_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_HWRST:
        begin
          state_q <= ST_RECOVER; // recovery timer starts [R24]
          cnt_q   <= '0;
        end
        ST_RECOVER:
          if (cnt_q == CNT_W'(RECOVER_CYC - 1))
          begin
            state_q <= ST_LOAD; // operational [R8]
            cnt_q   <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        ST_LOAD:
          if (load_done || load_tmo)
          begin
            state_q <= ST_CONFIG; // [R9]
            cnt_q   <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        ST_CONFIG:
          state_q <= ST_ATTACHED; // [R11]
        ST_ATTACHED:
          state_q <= ST_ATTACHED;
        default:
          state_q <= ST_HWRST;
      endcase
    end
  end

  // mode and test entry latched on the release [R22]
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      mode_q <= MODE_DEFAULT;
      test_q <= 1'b0;
    end
    else if (state_q == ST_HWRST)
    begin
      mode_q <= hrcs_mode_t'(pins_s.cfg_sel);
      test_q <= pins_s.test && pins_s.cfg_sel[1] && !pins_s.sclk;
    end
  end

  // led strap capture inside the hold window
  assign strap_now = state_q == ST_RECOVER && mode_q == MODE_STRAP && cnt_q == CNT_W'(STRAP_MIN_CYC);

  always_ff @(posedge aclk)
  begin
    if (core_clr)
      strap_q <= '0;
    else if (strap_now)
      strap_q <= pins_s.led; // [R15]
  end

  // eeprom kick, load result and attach
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      eeprom_start    <= 1'b0;
      cfg_use_default <= 1'b0;
      cfg_tmo_q       <= 1'b0;
      attach_q        <= 1'b0;
    end
    else
    begin
      eeprom_start <= state_q == ST_RECOVER && mode_q == MODE_EEPROM
                      && cnt_q == CNT_W'(RECOVER_CYC - 1); // [R8]
      if (state_q == ST_LOAD && (load_tmo || mode_q == MODE_DEFAULT || mode_q == MODE_STRAP))
        cfg_use_default <= 1'b1; // built-in values [R14] [R17]
      if (state_q == ST_LOAD && load_tmo && !load_done)
        cfg_tmo_q <= 1'b1;
      if (state_q == ST_CONFIG)
        attach_q <= 1'b1; // [R11]
    end
  end

  assign usb_attach = attach_q;
  assign cfg_strap  = strap_q;

  ////////////////////////////////////////////////////////////////////////////
  // pads, power and upstream bus reset

  // clock sources and transceivers off in reset
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      osc_en <= 1'b0; // [R6]
      pll_en <= 1'b0; // [R6]
      phy_en <= 1'b0; // pairs float [R3]
    end
    else
    begin
      osc_en <= 1'b1;
      pll_en <= 1'b1;
      phy_en <= 1'b1;
    end
  end

  // downstream power follows software once attached, port enable once configured
  always_ff @(posedge aclk)
  begin
    if (core_clr || usb_bus_reset)
    begin
      port_power_enable <= '0; // [R2] [R19]
      port_enable       <= '0; // only disabled, no reset sent down [R21]
    end
    else
    begin
      port_power_enable <= attach_q ? ctrl_q.ppe : '0;
      port_enable       <= ctrl_q.ppe & {NPORT{addr_q.configured}};
    end
  end

  // suspend state and tt flush
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      suspended_q <= 1'b0;
      tt_clear    <= 1'b0;
    end
    else
    begin
      tt_clear <= usb_bus_reset; // [R20]
      if (usb_bus_reset)
        suspended_q <= 1'b0; // [R20]
      else if (usb_suspend)
        suspended_q <= 1'b1;
    end
  end

  // request watchdog forces completion
  always_ff @(posedge aclk)
  begin
    if (core_clr || usb_bus_reset || !req_busy)
    begin
      req_cnt_q <= '0;
      req_abort <= 1'b0;
    end
    else if (req_cnt_q == CNT_W'(REQ_TMO_CYC - 1))
    begin
      req_cnt_q <= '0;
      req_abort <= 1'b1; // [R13]
    end
    else
    begin
      req_cnt_q <= req_cnt_q + 1'b1;
      req_abort <= 1'b0;
    end
  end

  // led drive: polarity from straps, green carries xnor chain in test
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      amber_led_pin_o   <= 1'b0;
      amber_led_pin_oe  <= 1'b0; // [R7]
      green_led2_pin_o  <= 1'b0;
      green_led2_pin_oe <= 1'b0; // [R7]
    end
    else
    begin
      amber_led_pin_oe  <= attach_q;
      amber_led_pin_o   <= ctrl_q.led_on[LED_AMBER] ^ strap_q[LED_AMBER]; // [R16]
      green_led2_pin_oe <= attach_q || test_q;
      if (test_q)
        green_led2_pin_o <= ~^pins_s.tp; // [R23]
      else
        green_led2_pin_o <= ctrl_q.led_on[LED_GREEN] ^ strap_q[LED_GREEN]; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  assign wr_go = axi_req.awvalid && axi_req.wvalid && !bvalid_q;
  assign rd_go = axi_req.arvalid && !rvalid_q;

  // channel handshakes
  always_comb
  begin
    axi_rsp.awready = wr_go;
    axi_rsp.wready  = wr_go;
    axi_rsp.bvalid  = bvalid_q;
    axi_rsp.bresp   = RESP_OKAY;
    axi_rsp.arready = !rvalid_q;
    axi_rsp.rvalid  = rvalid_q;
    axi_rsp.rdata   = rdata_q;
    axi_rsp.rresp   = RESP_OKAY;
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bvalid_q <= 1'b0;
    else if (wr_go)
      bvalid_q <= 1'b1;
    else if (axi_req.bready)
      bvalid_q <= 1'b0;
  end

  // registers; bus reset outranks a write [R5] [R18] [R19]
  always_ff @(posedge aclk)
  begin
    if (core_clr)
    begin
      ctrl_q <= hrcs_ctrl_t'(REG_RST);
      addr_q <= hrcs_addr_t'(REG_RST);
    end
    else if (usb_bus_reset)
    begin
      ctrl_q.ppe <= '0;
      addr_q     <= hrcs_addr_t'(REG_RST);
    end
    else if (wr_go && hit(axi_req.awaddr, REG_CTRL))
      ctrl_q <= hrcs_ctrl_t'(merge(ctrl_q, axi_req.wdata, axi_req.wstrb, CTRL_WMASK));
    else if (wr_go && hit(axi_req.awaddr, REG_ADDR))
      addr_q <= hrcs_addr_t'(merge(addr_q, axi_req.wdata, axi_req.wstrb, ADDR_WMASK));
  end

  assign dev_addr   = addr_q.dev_addr;
  assign configured = addr_q.configured;

  // status word
  always_comb
  begin
    stat           = hrcs_stat_t'(REG_RST);
    stat.state     = state_q;
    stat.mode      = mode_q;
    stat.strap     = strap_q;
    stat.test      = test_q;
    stat.cfg_tmo   = cfg_tmo_q;
    stat.attached  = attach_q;
    stat.suspended = suspended_q;
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    rd_word = REG_RST;
    if (hit(axi_req.araddr, REG_CTRL))
      rd_word = ctrl_q;
    else if (hit(axi_req.araddr, REG_ADDR))
      rd_word = addr_q;
    else if (hit(axi_req.araddr, REG_STAT))
      rd_word = stat;
  end

  // read data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= REG_RST;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
    end
    else if (axi_req.rready)
      rvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_hw_ports;
    !pins_s.hw_rst_n |=> port_power_enable == '0 && port_enable == '0;
  endproperty
  a_hw_ports: assert property (p_hw_ports) // [R2]
    else $error("port power on during reset");

  property p_hw_phy;
    !pins_s.hw_rst_n |=> !phy_en;
  endproperty
  a_hw_phy: assert property (p_hw_phy) // [R3]
    else $error("transceiver on during reset");

  property p_hw_wipe;
    !pins_s.hw_rst_n |=> state_q == ST_HWRST && ctrl_q == REG_RST && addr_q == REG_RST && !req_abort;
  endproperty
  a_hw_wipe: assert property (p_hw_wipe) // [R4] [R5] [R24]
    else $error("state kept across reset");

  property p_hw_clk;
    !pins_s.hw_rst_n |=> !osc_en && !pll_en;
  endproperty
  a_hw_clk: assert property (p_hw_clk) // [R6]
    else $error("clock source on during reset");

  property p_hw_led;
    !pins_s.hw_rst_n |=> !amber_led_pin_oe && !green_led2_pin_oe;
  endproperty
  a_hw_led: assert property (p_hw_led) // [R7]
    else $error("led driven during reset");

  property p_recover;
    state_q == ST_RECOVER && mode_q == MODE_EEPROM && cnt_q == CNT_W'(RECOVER_CYC - 1) && pins_s.hw_rst_n
      |=> state_q == ST_LOAD && eeprom_start;
  endproperty
  a_recover: assert property (p_recover) // [R8]
    else $error("eeprom read not started after recovery");

  property p_cfg_tmo;
    state_q == ST_LOAD && mode_q == MODE_EEPROM |-> cnt_q < CFG_TMO_CYC;
  endproperty
  a_cfg_tmo: assert property (p_cfg_tmo) // [R9]
    else $error("eeprom load overran its limit");

  property p_attach;
    state_q == ST_CONFIG && pins_s.hw_rst_n |=> usb_attach && state_q == ST_ATTACHED;
  endproperty
  a_attach: assert property (p_attach) // [R11]
    else $error("attach late");

  property p_req;
    req_busy && pins_s.hw_rst_n && !usb_bus_reset && req_cnt_q == CNT_W'(REQ_TMO_CYC - 1) |=> req_abort;
  endproperty
  a_req: assert property (p_req) // [R13]
    else $error("request watchdog missed");

  property p_strap;
    strap_now && pins_s.hw_rst_n |-> cnt_q <= STRAP_MAX_CYC ##1 strap_q == $past(pins_s.led);
  endproperty
  a_strap: assert property (p_strap) // [R15]
    else $error("strap capture wrong");

  property p_led_pol;
    attach_q && pins_s.hw_rst_n && strap_q[LED_AMBER] && !ctrl_q.led_on[LED_AMBER]
      |=> amber_led_pin_oe && amber_led_pin_o;
  endproperty
  a_led_pol: assert property (p_led_pol) // [R16]
    else $error("amber led polarity wrong");

  property p_busrst;
    usb_bus_reset && pins_s.hw_rst_n
      |=> dev_addr == '0 && !configured && port_power_enable == '0 && tt_clear && !suspended_q;
  endproperty
  a_busrst: assert property (p_busrst) // [R18] [R19] [R20]
    else $error("bus reset response wrong");

  property p_xnor;
    test_q && pins_s.hw_rst_n |=> green_led2_pin_oe && green_led2_pin_o == ~^$past(pins_s.tp);
  endproperty
  a_xnor: assert property (p_xnor) // [R23]
    else $error("xnor chain output wrong");

  c_attached: cover property (state_q == ST_ATTACHED);
  c_cfg_tmo: cover property (load_tmo && state_q == ST_LOAD);
  c_busrst: cover property (usb_bus_reset && attach_q);
  c_test: cover property (test_q && green_led2_pin_oe);

endmodule : hrcs_sequencer

// >>> sim/hrcs_host_model.sv
// hrcs_host_model: upstream host and configuration master stand-in
// assumes it shares aclk with the sequencer
module hrcs_host_model (
  input  wire logic aclk,
  input  wire logic slow,
  input  wire logic osc_en,
  input  wire logic eeprom_start,
  input  wire logic usb_attach,
  output logic      eeprom_done = 1'b0,
  output logic      smbus_done = 1'b0,
  output logic      usb_bus_reset = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int ce = 0;
  int cs = 0;
  int ca = 0;
  // load answers, prompt or slow, and bus reset after attach
  always @(posedge aclk)
  begin
    ce <= eeprom_start ? 1 : (ce != 0 ? ce + 1 : 0);
    cs <= osc_en ? cs + 1 : 0;
    ca <= usb_attach ? ca + 1 : 0;
    eeprom_done <= (ce == (slow ? 60 : 3));
    smbus_done <= (cs >= (slow ? 80 : 23));
    usb_bus_reset <= (ca == 40);
  end
endmodule : hrcs_host_model

// >>> sim/hrcs_sequencer_tb_top.sv
// hrcs_sequencer_tb_top: self-checking bench of the reset sequencer
// assumes shortened counts and the host model on the far side
module hrcs_sequencer_tb_top;
  import hrcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          aclk, aresetn, hwn, tm, sclk, slow, busy, sp, susp;
  logic [1:0]    sel, strap, cstr;
  logic [31:0]   tp, seed;
  logic [31:0]   mdl [0:3];
  hrcs_axi_req_t rq;
  hrcs_axi_rsp_t rs;
  logic          a_o, a_oe, g_o, g_oe, st, ed, sd, ucfg, att, ubr, ttc, abrt, phy, osc, pll, cfgd;
  logic [7:1]    ppe, pen;
  logic [6:0]    dadr;
  int            err_total = 0;
  int            checks_done = 0;
  int            nst, m;

  hrcs_sequencer #(.RECOVER_CYC(20), .CFG_TMO_CYC(50), .REQ_TMO_CYC(30)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs), .hw_reset_n_pin(hwn),
    .cfg_sel_pin(sel), .test_mode_pin(tm), .sclk_pin(sclk), .test_pins(tp),
    .amber_led_pin_i(a_oe ? a_o : strap[1]), .amber_led_pin_o(a_o), .amber_led_pin_oe(a_oe),
    .green_led2_pin_i(g_oe ? g_o : strap[0]), .green_led2_pin_o(g_o), .green_led2_pin_oe(g_oe),
    .self_powered(sp), .eeprom_start(st), .eeprom_done(ed), .smbus_done(sd),
    .cfg_use_default(ucfg), .cfg_strap(cstr), .usb_attach(att), .usb_bus_reset(ubr),
    .usb_suspend(susp), .tt_clear(ttc), .req_busy(busy), .req_abort(abrt),
    .port_power_enable(ppe), .port_enable(pen), .phy_en(phy), .osc_en(osc), .pll_en(pll),
    .dev_addr(dadr), .configured(cfgd));
  hrcs_host_model i_host (.aclk(aclk), .slow(slow), .osc_en(osc), .eeprom_start(st),
    .usb_attach(att), .eeprom_done(ed), .smbus_done(sd), .usb_bus_reset(ubr));

  // clock and load-start counter
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (st === 1'b1) nst++;

  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // bounded wait at falling edges for one handshake or event
  task hs(input int k, input int lim);
    logic [6:0] v;
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      v = {abrt, ttc, att, rs.rvalid, rs.arready, rs.bvalid, rs.awready};
      n++;
    end
    while (v[k] !== 1'b1 && n < lim);
    if (v[k] !== 1'b1)
    begin
      err_total++;
      conclude();
    end
  endtask : hs
  task wr(input logic [7:0] a, input logic [31:0] d);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    hs(0, 50);
    @(posedge aclk);
    rq.awvalid <= 1'b0;
    rq.wvalid <= 1'b0;
    hs(1, 50);
    @(posedge aclk);
    rq.bready <= 1'b0;
    if (a == REG_CTRL) mdl[0] = d & CTRL_WMASK;
    if (a == REG_ADDR) mdl[1] = d & ADDR_WMASK;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a, input string nm);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    hs(2, 50);
    @(posedge aclk);
    rq.arvalid <= 1'b0;
    hs(3, 50);
    chk(nm, mdl[a[3:2]], rs.rdata);
    @(posedge aclk);
    rq.rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // one hardware reset and bring-up in mode ms
  task up(input logic [1:0] ms, input logic t);
    hwn <= 1'b0;
    repeat (260) @(posedge aclk);
    chk("rst_out", 0, {ppe, pen, phy, osc, pll, a_oe, g_oe, att});
    sel <= ms;
    tm <= t;
    sclk <= 1'b0;
    strap <= 2'($random(seed));
    nst = 0;
    mdl = '{default: 0};
    hwn <= 1'b1;
    hs(4, 400);
    chk("start", ms == MODE_EEPROM, nst);
    chk("dflt", ms < 2 || (slow && !(ms == MODE_SMBUS && sp)), ucfg);
    @(posedge aclk);
  endtask : up

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h5fba3239;
    {aresetn, hwn, tm, sclk, slow, busy, sp, susp} = 8'h00;
    {sel, strap, tp} = 36'h0;
    rq = '0;
    rq.wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (m = 0; m < 4; m++)
    begin
      up(m[1:0], 1'b0);
      rd(REG_ADDR, "addr_rst");
      if (m == 1) chk("strap", strap, cstr);
      wr(REG_CTRL, $random(seed));
      wr(REG_ADDR, $random(seed));
      wr(8'h0c, $random(seed));
      rd(REG_CTRL, "ctrl");
      rd(8'h0c, "unmapped");
      chk("pwr", {mdl[0][7:1], mdl[0][7:1] & {7{mdl[1][8]}}}, {ppe, pen});
      if (m == 1) chk("led", mdl[0][9:8] ^ strap, {a_o, g_o});
      susp <= 1'b1;
      @(posedge aclk);
      susp <= 1'b0;
      mdl[2] = {1'b1, 1'b1, 2'b00, (m == 1 ? strap : 2'b00), m[1:0], ST_ATTACHED};
      rd(REG_STAT, "stat_susp");
      hs(5, 100);
      chk("busrst", 0, {dadr, cfgd, ppe, pen});
      mdl[0][7:1] = 7'h00;
      mdl[1] = 0;
      mdl[2][10] = 1'b0;
      @(posedge aclk);
      rd(REG_ADDR, "addr_br");
      rd(REG_STAT, "stat_br");
      $display("bring-up mode %0d done", m);
    end
    busy <= 1'b1;
    hs(6, 40);
    busy <= 1'b0;
    slow <= 1'b1;
    up(2'h2, 1'b0);
    up(2'h3, 1'b0);
    sp <= 1'b1;
    up(2'h3, 1'b0);
    slow <= 1'b0;
    up(2'h2, 1'b1);
    repeat (4)
    begin
      tp <= $random(seed);
      repeat (4) @(posedge aclk);
      chk("xnor", {1'b1, ~^tp}, {g_oe, g_o});
    end
    $display("timeout and test mode done");
    conclude();
  end
endmodule : hrcs_sequencer_tb_top
